// ### rtl/stc_pkg.sv
// constants for the sensor test, memory and offset control register group
// assumes a 25 MHz system clock and byte-wide register access
package stc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_SELF_TEST   = 8'h32;
  localparam logic [7:0] ADDR_NVM_CTRL    = 8'h33;
  localparam logic [7:0] ADDR_IF_WDT      = 8'h34;
  localparam logic [7:0] ADDR_OFFSET_COMP_CONTROL    = 8'h36;
  localparam logic [7:0] ADDR_OFFSET_COMP_SETTING = 8'h37;
  // reset values
  localparam logic [7:0] RST_SELF_TEST    = 8'h00;
  localparam logic [7:0] RST_IF_WDT       = 8'h00;
  localparam logic [7:0] RST_OFFSET_COMP_CONTROL     = 8'h00;
  localparam logic [7:0] RST_OFFSET_COMP_SETTING  = 8'h00;
  localparam logic [3:0] RST_NVM_REMAIN   = 4'hf;
  // self-test fields
  localparam int ST_AXIS_LSB  = 0;
  localparam int ST_SIGN_BIT  = 2;
  localparam int ST_AMP_BIT   = 4;
  // memory control fields
  localparam int NVM_MODE_BIT = 0;
  localparam int NVM_TRIG_BIT = 1;
  localparam int NVM_RDY_BIT  = 2;
  localparam int NVM_LOAD_BIT = 3;
  localparam int NVM_REM_LSB  = 4;
  // interface fields
  localparam int IF_3W_BIT    = 0;
  localparam int IF_WSEL_BIT  = 1;
  localparam int IF_WEN_BIT   = 2;
  // offset control fields
  localparam int OC_SLOW_LSB  = 0;
  localparam int OC_RDY_BIT   = 4;
  localparam int OC_TRIG_LSB  = 5;
  localparam int OC_RST_BIT   = 7;
  // offset setting fields
  localparam int OS_CUT_BIT   = 0;
  localparam int OS_TX_LSB    = 1;
  localparam int OS_TY_LSB    = 3;
  localparam int OS_TZ_LSB    = 5;
  // timing
  localparam int CLK_HZ          = 25_000_000;
  localparam int WDT_SHORT_US    = 1000;
  localparam int WDT_LONG_US     = 50000;
  localparam int WDT_SHORT_CYC   = CLK_HZ / 1_000_000 * WDT_SHORT_US;
  localparam int WDT_LONG_CYC    = CLK_HZ / 1_000_000 * WDT_LONG_US;
  // memory controller states
  typedef enum logic [2:0] {
    STC_NVM_IDLE = 3'b001,
    STC_NVM_LOAD = 3'b010,
    STC_NVM_PROG = 3'b100
  } stc_nvm_state_t;
endpackage

// ### rtl/stc_regs.sv
// control and status register group: self-test, memory controller,
// interface watchdog and offset compensation control
// assumes a byte register port synchronous to clk and external macros
// that report completion of memory and fast compensation jobs by a pulse
// the acceleration datapath, the offset value registers and the memory
// array sit outside; this block only drives their start pulses and
// tracks their busy state
`timescale 1ns/1ps
`default_nettype none

// Function
// - axis field 00 disables self-test, 01/10/11 excite x/y/z
// - during self-test only the tested axis readout is marked valid
// - sign bit one gives positive excitation, zero negative
// - amplitude bit one selects high deflection, zero low, low at reset
// - four-bit remaining write count decrements on each accepted write
// - writing one to load starts a reload of configuration from memory
// - ready reads zero during write or reload, one when idle
// - write trigger accepted only when unlocked and count above zero
// - program mode bit one unlocks memory writes, zero locks them
// - watchdog enable turns on data-line timeout in two-wire mode
// - watchdog period select: zero gives 1 ms, one gives 50 ms
// - offset reset one clears all three offset registers
// - fast compensation trigger 01/10/11 starts x/y/z, 00 nothing
// - compensation ready reads zero while running, one when idle
// - three bits enable slow compensation for z, y and x separately
// - target field: 00 and 11 zero g, 01 plus one g, 10 minus one g
// - corner select picks bandwidth/1000 or ten times that
module stc_regs
  import stc_pkg::*;
#(
  parameter int          WDT_SHORT   = WDT_SHORT_CYC,
  parameter int          WDT_LONG    = WDT_LONG_CYC,
  parameter logic [3:0]  REMAIN_INIT = RST_NVM_REMAIN
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // self-test
  output logic      [2:0]  st_excite,
  output logic             st_sign_pos,
  output logic             st_amp_high,
  output logic      [2:0]  axis_valid,
  // memory controller
  output logic             nvm_load_start,
  output logic             nvm_prog_start,
  input  wire logic        nvm_done,
  // serial interface
  output logic             three_wire_select,
  input  wire logic        two_wire_mode,
  input  wire logic        sda_in,
  output logic             wdt_timeout,
  // offset compensation
  output logic             offset_clear,
  output logic      [2:0]  fast_comp_start,
  input  wire logic        fast_comp_done,
  output logic             slow_comp_x_enable,
  output logic             slow_comp_y_enable,
  output logic             slow_comp_z_enable,
  output logic      [1:0]  target_x,
  output logic      [1:0]  target_y,
  output logic      [1:0]  target_z,
  output logic             corner_high
);

  // self-test fields
  logic [1:0]     st_axis;
  logic           st_sign;
  logic           st_amp;

  // memory controller fields and sequencer state
  logic           prog_mode;
  logic [3:0]     remain;
  stc_nvm_state_t nvm_state;
  stc_nvm_state_t next_nvm_state;

  // interface fields and the watchdog counter, sized for the long period
  logic           wdt_en;
  logic           wdt_sel;
  logic           three_wire_select_sel;
  logic [20:0]    wdt_cnt;

  // offset compensation fields
  logic [2:0]     slow_en;
  logic           comp_busy;
  logic [1:0]     tgt_x;
  logic [1:0]     tgt_y;
  logic [1:0]     tgt_z;
  logic           cut_off;

  // per-axis decodes, one bit or one pair per axis
  wire  [2:0]     excite_hot;
  wire  [2:0]     trig_hot;
  wire  [5:0]     tgt_raw;
  wire  [5:0]     tgt_fold;

  // read path
  logic [7:0]     next_rdata;

  // address decode
  wire sel_st  = (addr == ADDR_SELF_TEST);
  wire sel_nvm = (addr == ADDR_NVM_CTRL);
  wire sel_if  = (addr == ADDR_IF_WDT);
  wire sel_oc  = (addr == ADDR_OFFSET_COMP_CONTROL);
  wire sel_os  = (addr == ADDR_OFFSET_COMP_SETTING);

  // write strobes; an unmapped offset matches none and is ignored
  wire wr_st   = wr & sel_st;
  wire wr_nvm  = wr & sel_nvm;
  wire wr_if   = wr & sel_if;
  wire wr_oc   = wr & sel_oc;
  wire wr_os   = wr & sel_os;

  // memory trigger qualification; the lock is the stored mode bit, so
  // one write cannot both unlock and start a memory write
  wire nvm_rdy    = (nvm_state == STC_NVM_IDLE);
  wire load_req   = wr_nvm & wdata[NVM_LOAD_BIT] & nvm_rdy;
  wire prog_req   = wr_nvm & wdata[NVM_TRIG_BIT] & nvm_rdy
                    & prog_mode & (remain != 4'h0);

  // offset triggers; a fast trigger while one runs is dropped
  wire [1:0] trig = wdata[OC_TRIG_LSB +: 2];
  wire comp_req   = wr_oc & (trig != 2'b00) & ~comp_busy;
  wire clr_req    = wr_oc & wdata[OC_RST_BIT];

  // per-axis decode: axis code n selects axis n-1, code 00 none
  assign tgt_raw = {tgt_z, tgt_y, tgt_x};
  for (genvar ax = 0; ax < 3; ax++) begin : g_axis
    assign excite_hot[ax] = (st_axis == 2'(ax + 1));
    assign trig_hot[ax]   = (trig == 2'(ax + 1));
    // a stored 11 means zero g, the same as 00
    assign tgt_fold[2*ax +: 2] = (tgt_raw[2*ax +: 2] == 2'b11) ? 2'b00
                                 : tgt_raw[2*ax +: 2];
  end

  // self-test register
  // reserved bits are not stored and read back as zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_axis <= RST_SELF_TEST[ST_AXIS_LSB +: 2];
      st_sign <= RST_SELF_TEST[ST_SIGN_BIT];
      st_amp  <= RST_SELF_TEST[ST_AMP_BIT];
    end else if (wr_st) begin
      st_axis <= wdata[ST_AXIS_LSB +: 2];
      st_sign <= wdata[ST_SIGN_BIT];
      st_amp  <= wdata[ST_AMP_BIT];
    end
  end

  // self-test drive; sign and amplitude pass straight to the exciter
  // readouts are flagged valid on all axes only while self-test is off
  assign st_excite   = excite_hot;
  assign st_sign_pos = st_sign;
  assign st_amp_high = st_amp;
  assign axis_valid  = (st_axis == 2'b00) ? 3'b111 : st_excite;

  // program mode and remaining write count
  // the count moves only on an accepted trigger and cannot wrap, since
  // a zero count refuses the trigger
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prog_mode <= 1'b0;
      remain    <= REMAIN_INIT;
    end else begin
      // mode bit follows every write to the memory control register
      if (wr_nvm) begin
        prog_mode <= wdata[NVM_MODE_BIT];
      end
      if (prog_req) begin
        remain <= remain - 4'h1;
      end
    end
  end

  // memory controller sequencing
  // write and reload both start from idle only, so they never overlap;
  // a write that asks for both runs the memory write if it is accepted, otherwise the reload
  always_comb begin
    next_nvm_state = nvm_state;
    case (nvm_state)
      STC_NVM_IDLE: begin
        if (prog_req) begin
          next_nvm_state = STC_NVM_PROG;
        end else if (load_req) begin
          next_nvm_state = STC_NVM_LOAD;
        end
      end
      // reload runs until the far side reports done
      STC_NVM_LOAD: begin
        if (nvm_done) begin
          next_nvm_state = STC_NVM_IDLE;
        end
      end
      // memory write runs until the far side reports done
      STC_NVM_PROG: begin
        if (nvm_done) begin
          next_nvm_state = STC_NVM_IDLE;
        end
      end
      // an illegal code falls back to idle
      default: next_nvm_state = STC_NVM_IDLE;
    endcase
  end

  // memory state and start pulses
  // start pulses last one cycle; the far side must catch them
  // the state moves on the same edge as the pulse rises
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nvm_state      <= STC_NVM_IDLE;
      nvm_load_start <= 1'b0;
      nvm_prog_start <= 1'b0;
    end else begin
      nvm_state      <= next_nvm_state;
      // load start held back when the same write starts a memory write
      nvm_load_start <= load_req & ~prog_req;
      nvm_prog_start <= prog_req;
    end
  end

  // interface register
  // the three-wire bit leaves the block and is read back, nothing else here uses it
  // reserved bits 7:3 are not stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      three_wire_select_sel <= RST_IF_WDT[IF_3W_BIT];
      wdt_sel  <= RST_IF_WDT[IF_WSEL_BIT];
      wdt_en   <= RST_IF_WDT[IF_WEN_BIT];
    end else if (wr_if) begin
      three_wire_select_sel <= wdata[IF_3W_BIT];
      wdt_sel  <= wdata[IF_WSEL_BIT];
      wdt_en   <= wdata[IF_WEN_BIT];
    end
  end

  assign three_wire_select = three_wire_select_sel;

  // data-line watchdog: counts while the data line is held low
  // any high sample restarts the count, so only one unbroken low
  // stretch of the full period raises the timeout
  wire        wdt_run   = wdt_en & two_wire_mode & ~sda_in;
  // limits are one below the period because the count starts at zero
  wire [20:0] wdt_lim_short = 21'(WDT_SHORT - 1);
  wire [20:0] wdt_lim_long  = 21'(WDT_LONG - 1);
  wire [20:0] wdt_limit = wdt_sel ? wdt_lim_long : wdt_lim_short;
  wire        wdt_hit   = wdt_run & (wdt_cnt >= wdt_limit);

  // counter and registered timeout pulse; a period beyond the 21-bit
  // counter needs a wider one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdt_cnt     <= 21'h0;
      wdt_timeout <= 1'b0;
    end else begin
      // one-cycle timeout pulse, then the count starts over
      wdt_timeout <= wdt_hit;
      if (!wdt_run || wdt_hit) begin
        wdt_cnt <= 21'h0;
      end else begin
        wdt_cnt <= wdt_cnt + 21'h1;
      end
    end
  end

  // offset control: slow enables, busy flag, pulses
  // busy is set at the accepting edge and cleared by the done pulse;
  // set wins, though a trigger is only taken while idle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slow_en         <= RST_OFFSET_COMP_CONTROL[OC_SLOW_LSB +: 3];
      comp_busy       <= 1'b0;
      offset_clear    <= 1'b0;
      fast_comp_start <= 3'b000;
    end else begin
      // slow enables follow every write to the control register
      if (wr_oc) begin
        slow_en <= wdata[OC_SLOW_LSB +: 3];
      end
      if (comp_req) begin
        comp_busy <= 1'b1;
      end else if (fast_comp_done) begin
        comp_busy <= 1'b0;
      end
      // single-cycle pulses toward the offset and compensation logic
      offset_clear    <= clr_req;
      fast_comp_start <= comp_req ? trig_hot : 3'b000;
    end
  end

  // slow enables, bit 0 for x up to bit 2 for z
  // each enable goes straight to its axis filter
  assign slow_comp_x_enable = slow_en[0];
  assign slow_comp_y_enable = slow_en[1];
  assign slow_comp_z_enable = slow_en[2];

  // offset setting register
  // raw target codes are kept so that a stored 11 reads back as written
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cut_off <= RST_OFFSET_COMP_SETTING[OS_CUT_BIT];
      tgt_x   <= RST_OFFSET_COMP_SETTING[OS_TX_LSB +: 2];
      tgt_y   <= RST_OFFSET_COMP_SETTING[OS_TY_LSB +: 2];
      tgt_z   <= RST_OFFSET_COMP_SETTING[OS_TZ_LSB +: 2];
    end else if (wr_os) begin
      cut_off <= wdata[OS_CUT_BIT];
      tgt_x   <= wdata[OS_TX_LSB +: 2];
      tgt_y   <= wdata[OS_TY_LSB +: 2];
      tgt_z   <= wdata[OS_TZ_LSB +: 2];
    end
  end

  // targets folded to 00 zero, 01 plus one g, 10 minus one g
  assign target_x    = tgt_fold[1:0];
  assign target_y    = tgt_fold[3:2];
  assign target_z    = tgt_fold[5:4];
  // corner: zero gives bandwidth/1000, one gives ten times that
  assign corner_high = cut_off;

  // read mux, triggers read back zero
  // unmapped offsets and reserved bits read as zero as well; the load
  // bit reads one while a reload runs
  // only one register is selected at a time, so order does not matter
  always_comb begin
    next_rdata = 8'h00;
    if (sel_st) begin
      // bits 3 and 7:5 are reserved
      next_rdata[ST_AXIS_LSB +: 2] = st_axis;
      next_rdata[ST_SIGN_BIT]      = st_sign;
      next_rdata[ST_AMP_BIT]       = st_amp;
    end else if (sel_nvm) begin
      // the write trigger bit is write-only and stays zero here
      next_rdata[NVM_MODE_BIT]     = prog_mode;
      next_rdata[NVM_RDY_BIT]      = nvm_rdy;
      next_rdata[NVM_LOAD_BIT]     = (nvm_state == STC_NVM_LOAD);
      next_rdata[NVM_REM_LSB +: 4] = remain;
    end else if (sel_if) begin
      // bits 7:3 are reserved
      next_rdata[IF_3W_BIT]        = three_wire_select_sel;
      next_rdata[IF_WSEL_BIT]      = wdt_sel;
      next_rdata[IF_WEN_BIT]       = wdt_en;
    end else if (sel_oc) begin
      // trigger and offset reset bits are write-only, left at zero
      next_rdata[OC_SLOW_LSB +: 3] = slow_en;
      next_rdata[OC_RDY_BIT]       = ~comp_busy;
    end else if (sel_os) begin
      // raw target codes, an 11 reads back as 11
      next_rdata[OS_CUT_BIT]       = cut_off;
      next_rdata[OS_TX_LSB +: 2]   = tgt_x;
      next_rdata[OS_TY_LSB +: 2]   = tgt_y;
      next_rdata[OS_TZ_LSB +: 2]   = tgt_z;
    end
  end

  // read data one cycle after the read strobe
  // zero outside the answer cycle, so a stale byte is never seen
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? next_rdata : 8'h00;
    end
  end

endmodule
`default_nettype wire

// ### dv/stc_regs_monitor.sv
// port checker for the control register group
// assumes one clock domain, bound onto stc_regs
`timescale 1ns/1ps
`default_nettype none
module stc_regs_monitor
  import stc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic [2:0] st_excite,
  input wire logic [2:0] axis_valid,
  input wire logic       nvm_load_start,
  input wire logic       nvm_prog_start,
  input wire logic       nvm_done,
  input wire logic       offset_clear,
  input wire logic [2:0] fast_comp_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // a refused retrigger right after a memory write start
  sequence s_prog_busy;
    nvm_prog_start ##1 (!nvm_done && wr && addr == ADDR_NVM_CTRL
      && wdata[NVM_TRIG_BIT]);
  endsequence
  property p_axis; $onehot0(st_excite); endproperty
  property p_valid;
    axis_valid == ((st_excite == 3'h0) ? 3'h7 : st_excite);
  endproperty
  property p_prog;
    nvm_prog_start |-> $past(wr && addr == ADDR_NVM_CTRL
      && wdata[NVM_TRIG_BIT]);
  endproperty
  property p_load;
    nvm_load_start |-> $past(wr && addr == ADDR_NVM_CTRL
      && wdata[NVM_LOAD_BIT]);
  endproperty
  property p_busy; s_prog_busy |=> !nvm_prog_start; endproperty
  property p_clear;
    offset_clear == $past(wr && addr == ADDR_OFFSET_COMP_CONTROL && wdata[OC_RST_BIT]);
  endproperty
  property p_fast;
    fast_comp_start != 3'h0 |-> $onehot(fast_comp_start)
      && $past(wr && addr == ADDR_OFFSET_COMP_CONTROL && wdata[6:5] != 2'h0);
  endproperty
  property p_rd_trig;
    rd && addr == ADDR_OFFSET_COMP_CONTROL |=> rdata[7:5] == 3'h0;
  endproperty
  a_axis: assert property (p_axis) else $error("excite not one-hot");
  a_valid: assert property (p_valid) else $error("axis valid wrong");
  a_prog: assert property (p_prog) else $error("stray prog start");
  a_load: assert property (p_load) else $error("stray load start");
  a_busy: assert property (p_busy) else $error("prog while busy");
  a_clear: assert property (p_clear) else $error("offset clear");
  a_fast: assert property (p_fast) else $error("fast start wrong");
  a_rd_trig: assert property (p_rd_trig) else $error("trig reads 1");
endmodule
bind stc_regs stc_regs_monitor stc_regs_monitor_inst (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .st_excite(st_excite), .axis_valid(axis_valid),
  .nvm_load_start(nvm_load_start), .nvm_prog_start(nvm_prog_start),
  .nvm_done(nvm_done), .offset_clear(offset_clear),
  .fast_comp_start(fast_comp_start)
);
`default_nettype wire

// ### dv/stc_far_model.sv
// far-side model: memory macro and fast compensation engine
// assumes start pulses; answers a done pulse dly cycles later
`timescale 1ns/1ps
`default_nettype none
module stc_far_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] dly,
  input  wire logic       nvm_start,
  input  wire logic       comp_start,
  output logic            nvm_done,
  output logic            fast_comp_done
);
  logic [7:0] nvm_cnt;
  logic [7:0] comp_cnt;
  // count down from each start, done on the last count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nvm_cnt  <= 8'h00;
      comp_cnt <= 8'h00;
    end else begin
      nvm_cnt  <= nvm_start ? dly : nvm_cnt - {7'h0, nvm_cnt != 8'h00};
      comp_cnt <= comp_start ? dly : comp_cnt - {7'h0, comp_cnt != 8'h00};
    end
  end
  assign nvm_done       = nvm_cnt == 8'h01;
  assign fast_comp_done = comp_cnt == 8'h01;
endmodule
`default_nettype wire

// ### dv/test_stc_regs.sv
// self-checking bench for the control register group
// assumes short watchdog counts and a remain count of two
`timescale 1ns/1ps
`default_nettype none
module test_stc_regs;
  import stc_pkg::*;
  logic       clk = 0, rstn = 0, wr = 0, rd = 0, two_wire_mode = 0;
  logic       sda_in = 1, nvm_done, fast_comp_done, st_sign_pos, st_amp_high;
  logic       nvm_load_start, nvm_prog_start, three_wire_select, wdt_timeout;
  logic       offset_clear, slow_x, slow_y, slow_z, corner_high;
  logic [7:0] addr = 0, wdata = 0, rdata, d, dly = 8'h0a;
  logic [2:0] st_excite, axis_valid, fast_comp_start, e;
  logic [1:0] target_x, target_y, target_z;
  int         error_cnt = 0, checks = 0;
  always #20 clk = ~clk;
  stc_regs #(.WDT_SHORT(8), .WDT_LONG(20), .REMAIN_INIT(4'h2)) stc_regs_inst (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .st_excite(st_excite), .st_sign_pos(st_sign_pos),
    .st_amp_high(st_amp_high), .axis_valid(axis_valid),
    .nvm_load_start(nvm_load_start), .nvm_prog_start(nvm_prog_start),
    .nvm_done(nvm_done), .three_wire_select(three_wire_select),
    .two_wire_mode(two_wire_mode), .sda_in(sda_in), .wdt_timeout(wdt_timeout),
    .offset_clear(offset_clear), .fast_comp_start(fast_comp_start),
    .fast_comp_done(fast_comp_done), .slow_comp_x_enable(slow_x),
    .slow_comp_y_enable(slow_y), .slow_comp_z_enable(slow_z),
    .target_x(target_x), .target_y(target_y), .target_z(target_z),
    .corner_high(corner_high));
  stc_far_model stc_far_model_inst (.clk(clk), .rstn(rstn), .dly(dly),
    .nvm_start(nvm_load_start | nvm_prog_start),
    .comp_start(|fast_comp_start), .nvm_done(nvm_done),
    .fast_comp_done(fast_comp_done));
  // compare and count
  task automatic chk(input logic [7:0] seen, exp, input string what);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // register port cycles
  task automatic wreg(input logic [7:0] a, v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rget(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rreg(input logic [7:0] a, exp);
    logic [7:0] v;
    rget(a, v);
    chk(v, exp, "rdata");
  endtask
  // bounded wait for a ready bit
  task automatic poll(input logic [7:0] a, input int b);
    logic [7:0] v;
    for (int i = 0; i < 60; i++) begin
      rget(a, v);
      if (v[b] === 1'b1) return;
    end
    chk(8'h00, 8'h01, "ready wait");
    close_out();
  endtask
  // hold the data line low and count cycles to a timeout
  task automatic wdt(input logic [7:0] cfg, input logic tw, input int n);
    int k;
    k = 0;
    wreg(ADDR_IF_WDT, cfg);
    chk(three_wire_select, cfg[0], "three wire");
    @(posedge clk);
    two_wire_mode <= tw;
    sda_in        <= 1'b0;
    while (k < 30 && wdt_timeout !== 1'b1) begin
      @(posedge clk);
      #1 k++;
    end
    @(posedge clk);
    sda_in <= 1'b1;
    chk((n == 0) ? k == 30 : (k >= n && k <= n + 1), 1, "wdt");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    chk(st_amp_high, 0, "amp");
    rreg(ADDR_SELF_TEST, 8'h00);
    rreg(ADDR_NVM_CTRL, 8'h24);
    rreg(ADDR_OFFSET_COMP_CONTROL, 8'h10);
    rreg(8'h35, 8'h00);
    for (int i = 0; i < 16; i++) begin
      d = {3'h0, i[3], 1'b0, i[2], i[1:0]};
      e = (i[1:0] == 2'h0) ? 3'h0 : 3'h1 << (i[1:0] - 2'h1);
      wreg(ADDR_SELF_TEST, d);
      chk(st_excite, e, "excite");
      chk(axis_valid, (e == 3'h0) ? 3'h7 : e, "valid");
      chk({st_amp_high, st_sign_pos}, i[3:2], "amp sign");
      rreg(ADDR_SELF_TEST, d);
    end
    wreg(ADDR_NVM_CTRL, 8'h02);
    chk(nvm_prog_start, 0, "locked prog");
    wreg(ADDR_NVM_CTRL, 8'h01);
    rreg(ADDR_NVM_CTRL, 8'h25);
    for (int i = 2; i >= 0; i--) begin
      poll(ADDR_NVM_CTRL, NVM_RDY_BIT);
      wreg(ADDR_NVM_CTRL, 8'h03);
      chk(nvm_prog_start, i > 0, "prog");
      wreg(ADDR_NVM_CTRL, 8'h03);
      chk(nvm_prog_start, 0, "busy prog");
      rreg(ADDR_NVM_CTRL, (i == 2) ? 8'h11 : (i == 1) ? 8'h01 : 8'h05);
    end
    dly = 8'h04;
    poll(ADDR_NVM_CTRL, NVM_RDY_BIT);
    wreg(ADDR_NVM_CTRL, 8'h08);
    chk(nvm_load_start, 1, "load");
    rreg(ADDR_NVM_CTRL, 8'h08);
    poll(ADDR_NVM_CTRL, NVM_RDY_BIT);
    wreg(ADDR_NVM_CTRL, 8'h00);
    chk(nvm_load_start, 0, "no load");
    wdt(8'h04, 1'b1, 8);
    wdt(8'h07, 1'b1, 20);
    wdt(8'h02, 1'b1, 0);
    wdt(8'h04, 1'b0, 0);
    wreg(ADDR_OFFSET_COMP_CONTROL, 8'h87);
    chk(offset_clear, 1, "clear");
    chk({slow_z, slow_y, slow_x}, 3'h7, "slow");
    rreg(ADDR_OFFSET_COMP_CONTROL, 8'h17);
    wreg(ADDR_OFFSET_COMP_CONTROL, 8'h05);
    chk(offset_clear, 0, "clear");
    rreg(ADDR_OFFSET_COMP_CONTROL, 8'h15);
    for (int t = 0; t < 4; t++) begin
      poll(ADDR_OFFSET_COMP_CONTROL, OC_RDY_BIT);
      wreg(ADDR_OFFSET_COMP_CONTROL, {1'b0, t[1:0], 5'h00});
      e = (t == 0) ? 3'h0 : 3'h1 << (t[1:0] - 2'h1);
      chk(fast_comp_start, e, "fast");
      rreg(ADDR_OFFSET_COMP_CONTROL, (t == 0) ? 8'h10 : 8'h00);
    end
    wreg(ADDR_OFFSET_COMP_CONTROL, 8'h20);
    chk(fast_comp_start, 0, "busy fast");
    for (int t = 0; t < 4; t++) begin
      d = {1'b0, t[1:0], t[1:0], t[1:0], t[0]};
      e = (t == 3) ? 3'h0 : t[2:0];
      wreg(ADDR_OFFSET_COMP_SETTING, d);
      chk({target_z, target_y, target_x}, {3{e[1:0]}}, "target");
      chk(corner_high, t[0], "corner");
      rreg(ADDR_OFFSET_COMP_SETTING, d);
    end
    close_out();
  end
endmodule
`default_nettype wire
